/* upstream_msg_pkg.sv */
// Package: link codes and state types
//
// Operation
// RQ1: Switch request names 8-bit target channel.
// RQ2: Options use one-octet type and length.
// RQ3: Ranging 0 initial, 1 station maintenance.
// RQ4: Ranging 2 lets modem pick either region.
// RQ5: Ranging 3 transmits at once, no maintenance.
// RQ6: No ranging tuple means initial maintenance.
// RQ7: Headend accepts initial maintenance anyway.
// RQ8: Modem answers every switch request with response; code sends none for a request that ends while the modem is not idle.
// RQ9: Response goes out before switching channels.
// RQ10: Requests during a switch may be ignored.
// RQ11: Same channel request answered as already there.
// RQ12: Re-range after switch, no new registration.
// RQ13: Response echoes the request's 8-bit channel.
// RQ14: Flow add carries sender-assigned unique transaction.
// RQ15: At most one flow per direction.
// RQ16: Flow parameters always present, others optional.
// RQ17: Privacy adds key sequence, digest last.
// RQ18: Modem flows get unique references per message.
// RQ19: Modem classifiers get unique references per message.
// RQ20: Modem may name a service class instead.
// RQ21: Headend links by flow id, upstream adds identifier.
// RQ22: Headend classifier ids unique per flow.
// RQ23: Unknown tuples skipped by length.
package upstream_msg_pkg;
   // ==========================================
   // Message codes and positions
   localparam logic [7:0] MSG_SWITCH_REQ = 8'h10;
   localparam logic [7:0] MSG_SWITCH_RSP = 8'h11;
   localparam logic [7:0] MSG_FLOW_ADD = 8'h12;
   localparam logic [7:0] POS_TYPE = 8'h00;
   localparam logic [7:0] POS_CHAN = 8'h01;
   localparam logic [7:0] POS_TLV = 8'h02;
   localparam logic [7:0] POS_B2 = 8'h02;
   localparam logic [7:0] SW_RSP_LEN = 8'h03;
   localparam logic [7:0] SW_REQ_LEN = 8'h02;
   localparam logic [7:0] SW_REQ_RNG_LEN = 8'h05;
   localparam logic [7:0] HDR_LEN = 8'h03;
   localparam int MSG_MAX_BYTES = 32'h24;
   localparam int FLOW_ADD_MAX = 32'h23;
   localparam int CLS_MAX = 32'h3;
   localparam logic [7:0] CHAN_RESET = 8'h00;
   localparam logic [15:0] TXN_FIRST = 16'h0001;
   // ==========================================
   // TLV types and lengths
   localparam logic [7:0] TLV_RANGING = 8'h01;
   localparam logic [7:0] TLV_CLASSIFIER = 8'h16;
   localparam logic [7:0] TLV_SF_UP = 8'h18;
   localparam logic [7:0] TLV_SF_DN = 8'h19;
   localparam logic [7:0] TLV_HEADER_SUPPRESSION = 8'h1A;
   localparam logic [7:0] TLV_KEY_SEQ = 8'h1B;
   localparam logic [7:0] TLV_DIGEST = 8'h1C;
   localparam logic [7:0] LEN_RANGING = 8'h01;
   localparam logic [7:0] LEN_SF = 8'h03;
   localparam logic [7:0] LEN_CLS = 8'h02;
   localparam logic [7:0] LEN_HDR_SUP = 8'h02;
   localparam logic [7:0] LEN_KEY = 8'h01;
   localparam logic [7:0] LEN_DIGEST = 8'h01;
   localparam logic [7:0] LEN_HSF_UP = 8'h05;
   localparam logic [7:0] LEN_HSF_DN = 8'h03;
   localparam logic [7:0] LEN_HCLS = 8'h03;
   // ==========================================
   // Field values
   localparam logic [7:0] RNG_INITIAL = 8'h00;
   localparam logic [7:0] RNG_STATION = 8'h01;
   localparam logic [7:0] RNG_EITHER = 8'h02;
   localparam logic [7:0] RNG_NONE = 8'h03;
   localparam logic [7:0] ST_COMPLY = 8'h00;
   localparam logic [7:0] ST_ALREADY = 8'h01;
   localparam logic [7:0] REF_UP = 8'h01;
   localparam logic [7:0] REF_DN = 8'h02;
   localparam logic [7:0] CLS_REF_FIRST = 8'h01;
   localparam logic [7:0] SF_KIND_QOS = 8'h00;
   localparam logic [7:0] SF_KIND_CLASS = 8'h01;
   // ==========================================
   // State types
   typedef enum logic [3:0] {M_IDLE = 4'h1, M_RSP = 4'h2, M_RANGE = 4'h4, M_FADD = 4'h8} modem_state_t;
   typedef enum logic [1:0] {H_IDLE = 2'h1, H_TX = 2'h2} head_state_t;
   typedef enum logic [2:0] {P_TYPE = 3'h1, P_LEN = 3'h2, P_VAL = 3'h4} walk_phase_t;
endpackage : upstream_msg_pkg

/* msg_link_if.sv */
// Interface: byte links
`timescale 1ns/1ps
interface msg_link_if;
   logic h2m_valid;
   logic [7:0] h2m_data;
   logic h2m_last;
   logic m2h_valid;
   logic [7:0] m2h_data;
   logic m2h_last;
   modport modem (input h2m_valid, h2m_data, h2m_last, output m2h_valid, m2h_data, m2h_last);
   modport headend (output h2m_valid, h2m_data, h2m_last, input m2h_valid, m2h_data, m2h_last);
endinterface : msg_link_if

/* tlv_walker.sv */
// Module: tuple byte roles
`timescale 1ns/1ps
module tlv_walker (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Byte stream
   input wire logic start,
   input wire logic bvalid,
   input wire logic [7:0] bdata,
   // Role of the current byte
   output logic at_type,
   output logic at_len,
   output logic at_val,
   output logic [7:0] tlv_type
);
   typedef struct packed {
      upstream_msg_pkg::walk_phase_t phase;
      logic [7:0] ttype;
      logic [7:0] remain;
   } walk_reg_t;

   walk_reg_t r_reg;
   walk_reg_t r_next;

   assign at_type = bvalid && (start || r_reg.phase == upstream_msg_pkg::P_TYPE);
   assign at_len = bvalid && !start && r_reg.phase == upstream_msg_pkg::P_LEN;
   assign at_val = bvalid && !start && r_reg.phase == upstream_msg_pkg::P_VAL;
   assign tlv_type = r_reg.ttype;

   // ==========================================
   // Walk; any type is stepped over by its length, known or not
   always_comb begin
      r_next = r_reg;
      if (at_type) begin
         r_next.ttype = bdata; // RQ2
         r_next.phase = upstream_msg_pkg::P_LEN;
      end else if (at_len) begin
         r_next.remain = bdata; // RQ23
         r_next.phase = (bdata == 8'h00) ? upstream_msg_pkg::P_TYPE : upstream_msg_pkg::P_VAL;
      end else if (at_val) begin
         r_next.remain = r_reg.remain - 8'h01;
         if (r_reg.remain == 8'h01) begin
            r_next.phase = upstream_msg_pkg::P_TYPE; // RQ23
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r_reg <= '{phase: upstream_msg_pkg::P_TYPE, ttype: 8'h00, remain: 8'h00};
      end else begin
         r_reg <= r_next;
      end
   end
endmodule : tlv_walker

/* subscriber_modem_end.sv */
// Module: modem end
`timescale 1ns/1ps
module subscriber_modem_end #(
   parameter int MSG_MAX = upstream_msg_pkg::MSG_MAX_BYTES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Link to headend
   msg_link_if.modem link,
   // Channel state
   input wire logic chan_load,
   input wire logic [7:0] chan_load_val,
   output logic [7:0] up_chan,
   output logic range_active,
   output logic [1:0] range_mode,
   input wire logic range_done,
   output logic switch_done,
   // Flow add command
   input wire logic fa_start,
   input wire logic fa_up,
   input wire logic fa_dn,
   input wire logic fa_use_class,
   input wire logic [7:0] fa_param,
   input wire logic [1:0] fa_cls_count,
   input wire logic fa_header_suppression,
   input wire logic privacy_en,
   input wire logic [7:0] key_seq,
   input wire logic [7:0] digest,
   output logic fa_ready,
   output logic fa_sent,
   output logic [15:0] fa_txn
);
   if (MSG_MAX < upstream_msg_pkg::FLOW_ADD_MAX) begin : g_size_check
      $error("MSG_MAX cannot hold the longest flow add request");
   end

   typedef logic [MSG_MAX-1:0][7:0] buf_t;
   typedef struct packed {
      upstream_msg_pkg::modem_state_t st;
      logic [7:0] cur_chan;
      logic [7:0] req_chan;
      logic req_rng_seen;
      logic [7:0] req_rng_val;
      logic [7:0] rx_pos;
      logic [7:0] rx_type;
      logic [7:0] rx_chan;
      logic rx_rng_seen;
      logic [7:0] rx_rng_val;
      buf_t tx_buf;
      logic [7:0] tx_left;
      logic [15:0] txn;
      logic [1:0] rmode;
      logic sw_done;
      logic fa_done;
   } modem_reg_t;

   modem_reg_t r_reg;
   modem_reg_t r_next;
   logic tlv_val;
   logic [7:0] tlv_type;
   logic sw_commit;
   logic fa_go;

   // ==========================================
   // Tuple walker over the request options
   tlv_walker u_walk (
      .clk(clk),
      .resetn(resetn),
      .start(link.h2m_valid && r_reg.rx_pos == upstream_msg_pkg::POS_TLV),
      .bvalid(link.h2m_valid),
      .bdata(link.h2m_data),
      .at_type(),
      .at_len(),
      .at_val(tlv_val),
      .tlv_type(tlv_type)
   );

   // ==========================================
   // Outputs
   assign link.m2h_valid = r_reg.st == upstream_msg_pkg::M_RSP || r_reg.st == upstream_msg_pkg::M_FADD;
   assign link.m2h_data = r_reg.tx_buf[0];
   assign link.m2h_last = link.m2h_valid && r_reg.tx_left == 8'h01;
   assign up_chan = r_reg.cur_chan;
   assign range_active = r_reg.st == upstream_msg_pkg::M_RANGE;
   assign range_mode = r_reg.rmode;
   assign switch_done = r_reg.sw_done;
   assign fa_sent = r_reg.fa_done;
   assign fa_txn = r_reg.txn;

   // Busy modem drops a request; headend does not retry
   assign sw_commit = link.h2m_valid && link.h2m_last && r_reg.rx_type == upstream_msg_pkg::MSG_SWITCH_REQ
      && r_reg.rx_pos >= upstream_msg_pkg::POS_CHAN && r_reg.st == upstream_msg_pkg::M_IDLE; // RQ10
   // Switch request takes the idle slot first
   assign fa_ready = r_reg.st == upstream_msg_pkg::M_IDLE && !sw_commit;
   assign fa_go = fa_start && fa_ready && (fa_up || fa_dn); // RQ15 RQ16

   // ==========================================
   // Next state
   always_comb begin
      buf_t b;
      logic [7:0] k;
      logic [7:0] sf_ref;
      logic [7:0] sf_kind;
      b = '0;
      k = 8'h00;
      sf_ref = 8'h00;
      sf_kind = 8'h00;
      r_next = r_reg;
      r_next.sw_done = 1'b0;
      r_next.fa_done = 1'b0;
      if (chan_load) begin
         r_next.cur_chan = chan_load_val;
      end
      // Receive side
      if (link.h2m_valid) begin
         if (link.h2m_last) begin
            r_next.rx_pos = upstream_msg_pkg::POS_TYPE;
         end else if (r_reg.rx_pos != 8'hFF) begin
            r_next.rx_pos = r_reg.rx_pos + 8'h01;
         end
         if (r_reg.rx_pos == upstream_msg_pkg::POS_TYPE) begin
            r_next.rx_type = link.h2m_data;
            r_next.rx_rng_seen = 1'b0;
         end
         if (r_reg.rx_pos == upstream_msg_pkg::POS_CHAN) begin
            r_next.rx_chan = link.h2m_data; // RQ1
         end
         if (r_reg.rx_pos >= upstream_msg_pkg::POS_TLV && tlv_val && !r_reg.rx_rng_seen
             && tlv_type == upstream_msg_pkg::TLV_RANGING) begin
            r_next.rx_rng_seen = 1'b1; // RQ2
            r_next.rx_rng_val = link.h2m_data;
         end
      end
      if (sw_commit) begin
         r_next.req_chan = r_next.rx_chan;
         r_next.req_rng_seen = r_next.rx_rng_seen;
         r_next.req_rng_val = r_next.rx_rng_val;
         b[2:0] = {(r_next.rx_chan == r_reg.cur_chan) ? upstream_msg_pkg::ST_ALREADY : upstream_msg_pkg::ST_COMPLY,
            r_next.rx_chan, upstream_msg_pkg::MSG_SWITCH_RSP}; // RQ8 RQ11 RQ13
         r_next.tx_buf = b;
         r_next.tx_left = upstream_msg_pkg::SW_RSP_LEN;
         r_next.st = upstream_msg_pkg::M_RSP;
      end
      // Transmit side
      if (link.m2h_valid) begin
         r_next.tx_buf = {8'h00, r_reg.tx_buf[MSG_MAX-1:1]};
         r_next.tx_left = r_reg.tx_left - 8'h01;
         if (r_reg.tx_left == 8'h01) begin
            r_next.st = upstream_msg_pkg::M_IDLE;
            if (r_reg.st == upstream_msg_pkg::M_FADD) begin
               r_next.fa_done = 1'b1;
            end else if (r_reg.req_chan != r_reg.cur_chan) begin
               // Channel moves only once the response has left on the old one
               r_next.cur_chan = r_reg.req_chan; // RQ9
               if (r_reg.req_rng_seen && r_reg.req_rng_val == upstream_msg_pkg::RNG_NONE) begin
                  r_next.sw_done = 1'b1; // RQ5
               end else begin
                  r_next.st = upstream_msg_pkg::M_RANGE; // RQ12
                  if (!r_reg.req_rng_seen || r_reg.req_rng_val > upstream_msg_pkg::RNG_NONE) begin
                     r_next.rmode = upstream_msg_pkg::RNG_INITIAL[1:0]; // RQ6
                  end else begin
                     r_next.rmode = r_reg.req_rng_val[1:0]; // RQ3 RQ4
                  end
               end
            end
         end
      end
      // Ranging ends the switch; registration is not repeated
      if (r_reg.st == upstream_msg_pkg::M_RANGE && range_done) begin
         r_next.st = upstream_msg_pkg::M_IDLE; // RQ12
         r_next.sw_done = 1'b1;
      end
      // Flow add request build
      if (fa_go) begin
         b[2:0] = {r_reg.txn[7:0], r_reg.txn[15:8], upstream_msg_pkg::MSG_FLOW_ADD}; // RQ14
         k = upstream_msg_pkg::HDR_LEN;
         sf_kind = fa_use_class ? upstream_msg_pkg::SF_KIND_CLASS : upstream_msg_pkg::SF_KIND_QOS; // RQ20
         if (fa_up) begin
            b[k+:5] = {fa_param, sf_kind, upstream_msg_pkg::REF_UP, upstream_msg_pkg::LEN_SF,
               upstream_msg_pkg::TLV_SF_UP}; // RQ18
            k = k + 8'h05;
         end
         if (fa_dn) begin
            b[k+:5] = {fa_param, sf_kind, upstream_msg_pkg::REF_DN, upstream_msg_pkg::LEN_SF,
               upstream_msg_pkg::TLV_SF_DN}; // RQ18
            k = k + 8'h05;
         end
         // Classifiers bind to the upstream flow when there is one
         sf_ref = fa_up ? upstream_msg_pkg::REF_UP : upstream_msg_pkg::REF_DN;
         for (int i = 0; i < upstream_msg_pkg::CLS_MAX; i++) begin
            if (i < int'(fa_cls_count)) begin
               b[k+:4] = {sf_ref, 8'(i + 1), upstream_msg_pkg::LEN_CLS, upstream_msg_pkg::TLV_CLASSIFIER}; // RQ19
               k = k + 8'h04;
            end
         end
         if (fa_header_suppression && fa_cls_count != 2'h0) begin
            b[k+:4] = {sf_ref, upstream_msg_pkg::CLS_REF_FIRST, upstream_msg_pkg::LEN_HDR_SUP,
               upstream_msg_pkg::TLV_HEADER_SUPPRESSION}; // RQ16 RQ19
            k = k + 8'h04;
         end
         if (privacy_en) begin
            b[k+:3] = {key_seq, upstream_msg_pkg::LEN_KEY, upstream_msg_pkg::TLV_KEY_SEQ}; // RQ17
            k = k + 8'h03;
            b[k+:3] = {digest, upstream_msg_pkg::LEN_DIGEST, upstream_msg_pkg::TLV_DIGEST}; // RQ17
            k = k + 8'h03;
         end
         r_next.tx_buf = b;
         r_next.tx_left = k;
         r_next.txn = r_reg.txn + 16'h0001; // RQ14
         r_next.st = upstream_msg_pkg::M_FADD;
      end
   end

   // ==========================================
   // State register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r_reg <= '0;
         r_reg.st <= upstream_msg_pkg::M_IDLE;
         r_reg.cur_chan <= upstream_msg_pkg::CHAN_RESET;
         r_reg.txn <= upstream_msg_pkg::TXN_FIRST;
      end else begin
         r_reg <= r_next;
      end
   end
endmodule : subscriber_modem_end

/* headend_controller_end.sv */
// Module: headend end
`timescale 1ns/1ps
module headend_controller_end #(
   parameter int MSG_MAX = upstream_msg_pkg::MSG_MAX_BYTES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Link to modem
   msg_link_if.headend link,
   // Switch command
   input wire logic sw_start,
   input wire logic [7:0] sw_chan,
   input wire logic sw_rng_en,
   input wire logic [7:0] sw_rng_val,
   // Flow add command
   input wire logic fa_start,
   input wire logic fa_dir_up,
   input wire logic [15:0] fa_sfid,
   input wire logic [15:0] fa_upstream_service_identifier,
   input wire logic [7:0] fa_qos,
   input wire logic [1:0] fa_cls_count,
   input wire logic privacy_en,
   input wire logic [7:0] key_seq,
   input wire logic [7:0] digest,
   output logic cmd_ready,
   output logic [15:0] fa_txn,
   // Received message report
   output logic rx_valid,
   output logic [7:0] rx_type,
   output logic [7:0] rx_b1,
   output logic [7:0] rx_b2
);
   if (MSG_MAX < upstream_msg_pkg::FLOW_ADD_MAX) begin : g_size_check
      $error("MSG_MAX cannot hold the longest request");
   end

   typedef logic [MSG_MAX-1:0][7:0] buf_t;
   typedef struct packed {
      upstream_msg_pkg::head_state_t st;
      buf_t tx_buf;
      logic [7:0] tx_left;
      logic [15:0] txn;
      logic [7:0] rx_pos;
      logic [7:0] rx_type;
      logic [7:0] rx_b1;
      logic [7:0] rx_b2;
      logic rx_done;
   } head_reg_t;

   head_reg_t r_reg;
   head_reg_t r_next;

   assign link.h2m_valid = r_reg.st == upstream_msg_pkg::H_TX;
   assign link.h2m_data = r_reg.tx_buf[0];
   assign link.h2m_last = link.h2m_valid && r_reg.tx_left == 8'h01;
   assign cmd_ready = r_reg.st == upstream_msg_pkg::H_IDLE;
   assign fa_txn = r_reg.txn;
   assign rx_valid = r_reg.rx_done;
   assign rx_type = r_reg.rx_type;
   assign rx_b1 = r_reg.rx_b1;
   assign rx_b2 = r_reg.rx_b2;

   // ==========================================
   // Next state
   always_comb begin
      buf_t b;
      logic [7:0] k;
      b = '0;
      k = 8'h00;
      r_next = r_reg;
      r_next.rx_done = 1'b0;
      // Any ranging outcome is accepted
      if (link.m2h_valid) begin
         r_next.rx_pos = link.m2h_last ? upstream_msg_pkg::POS_TYPE : r_reg.rx_pos + 8'h01;
         if (r_reg.rx_pos == upstream_msg_pkg::POS_TYPE) begin
            r_next.rx_type = link.m2h_data;
         end
         if (r_reg.rx_pos == upstream_msg_pkg::POS_CHAN) begin
            r_next.rx_b1 = link.m2h_data;
         end
         if (r_reg.rx_pos == upstream_msg_pkg::POS_B2) begin
            r_next.rx_b2 = link.m2h_data;
         end
         r_next.rx_done = link.m2h_last; // RQ7
      end
      if (link.h2m_valid) begin
         r_next.tx_buf = {8'h00, r_reg.tx_buf[MSG_MAX-1:1]};
         r_next.tx_left = r_reg.tx_left - 8'h01;
         if (r_reg.tx_left == 8'h01) begin
            r_next.st = upstream_msg_pkg::H_IDLE;
         end
      end
      // Switch request wins a tie
      if (cmd_ready && sw_start) begin
         b[1:0] = {sw_chan, upstream_msg_pkg::MSG_SWITCH_REQ}; // RQ1
         r_next.tx_left = upstream_msg_pkg::SW_REQ_LEN;
         if (sw_rng_en) begin
            b[4:2] = {sw_rng_val, upstream_msg_pkg::LEN_RANGING, upstream_msg_pkg::TLV_RANGING}; // RQ2
            r_next.tx_left = upstream_msg_pkg::SW_REQ_RNG_LEN;
         end
         r_next.tx_buf = b;
         r_next.st = upstream_msg_pkg::H_TX;
      end else if (cmd_ready && fa_start) begin
         b[2:0] = {r_reg.txn[7:0], r_reg.txn[15:8], upstream_msg_pkg::MSG_FLOW_ADD}; // RQ14
         k = upstream_msg_pkg::HDR_LEN;
         if (fa_dir_up) begin
            b[k+:7] = {fa_qos, fa_upstream_service_identifier[7:0], fa_upstream_service_identifier[15:8],
               fa_sfid[7:0], fa_sfid[15:8], upstream_msg_pkg::LEN_HSF_UP, upstream_msg_pkg::TLV_SF_UP}; // RQ21
            k = k + 8'h07;
         end else begin
            b[k+:5] = {fa_qos, fa_sfid[7:0], fa_sfid[15:8], upstream_msg_pkg::LEN_HSF_DN,
               upstream_msg_pkg::TLV_SF_DN}; // RQ15 RQ16
            k = k + 8'h05;
         end
         for (int i = 0; i < upstream_msg_pkg::CLS_MAX; i++) begin
            if (i < int'(fa_cls_count)) begin
               b[k+:5] = {fa_sfid[7:0], fa_sfid[15:8], 8'(i + 1), upstream_msg_pkg::LEN_HCLS,
                  upstream_msg_pkg::TLV_CLASSIFIER}; // RQ21 RQ22
               k = k + 8'h05;
            end
         end
         if (privacy_en) begin
            b[k+:3] = {key_seq, upstream_msg_pkg::LEN_KEY, upstream_msg_pkg::TLV_KEY_SEQ}; // RQ17
            k = k + 8'h03;
            b[k+:3] = {digest, upstream_msg_pkg::LEN_DIGEST, upstream_msg_pkg::TLV_DIGEST}; // RQ17
            k = k + 8'h03;
         end
         r_next.tx_buf = b;
         r_next.tx_left = k;
         r_next.txn = r_reg.txn + 16'h0001; // RQ14
         r_next.st = upstream_msg_pkg::H_TX;
      end
   end

   // ==========================================
   // State register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r_reg <= '0;
         r_reg.st <= upstream_msg_pkg::H_IDLE;
         r_reg.txn <= upstream_msg_pkg::TXN_FIRST;
      end else begin
         r_reg <= r_next;
      end
   end
endmodule : headend_controller_end

/* link_properties.sv */
// Checker: link rules
`timescale 1ns/1ps
module link_properties (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Headend to modem
   input wire logic h2m_valid,
   input wire logic [7:0] h2m_data,
   input wire logic h2m_last,
   // Modem to headend
   input wire logic m2h_valid,
   input wire logic [7:0] m2h_data,
   input wire logic m2h_last
);
   // ==========================================
   // Byte position and tuple walk
   logic [5:0] hp_reg, mp_reg;
   logic [7:0] hch_reg, mt_reg, rem_reg;
   logic [15:0] tx_reg;
   logic len_reg, up_reg, sf_reg, key_reg;
   // Type byte of a flow add tuple
   wire at_t = m2h_valid && mp_reg > 6'h02 && !len_reg && rem_reg == 8'h00;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         {hp_reg, mp_reg, hch_reg, mt_reg, rem_reg, tx_reg, len_reg, up_reg, sf_reg, key_reg} <= '0;
      end else begin
         if (h2m_valid) hp_reg <= h2m_last ? 6'h00 : hp_reg + 6'h01;
         if (h2m_valid && hp_reg == 6'h01 && $past(h2m_data) == 8'h10) hch_reg <= h2m_data;
         if (m2h_valid) begin
            mp_reg <= m2h_last ? 6'h00 : mp_reg + 6'h01;
            rem_reg <= len_reg ? m2h_data : rem_reg - {7'h00, rem_reg != 8'h00};
            len_reg <= at_t && !m2h_last;
            up_reg <= !m2h_last && (up_reg || at_t && m2h_data == 8'h18);
            sf_reg <= !m2h_last && (sf_reg || at_t && m2h_data[7:1] == 7'h0C);
            key_reg <= !m2h_last && (key_reg || at_t && m2h_data == 8'h1B);
         end
         if (m2h_valid && mp_reg == 6'h00) mt_reg <= m2h_data;
         if (m2h_valid && mp_reg == 6'h02 && mt_reg == 8'h12) tx_reg <= {$past(m2h_data), m2h_data};
      end
   end
   // ==========================================
   // Properties
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   sequence rsp_tail;
      m2h_valid && !m2h_last ##1 m2h_valid && m2h_last;
   endsequence
   sequence dig_tail;
      m2h_valid && m2h_data == 8'h01 && !m2h_last ##1 m2h_valid && m2h_last;
   endsequence
   rsp_shape_a: assert property (m2h_valid && mp_reg == 6'h00 && m2h_data == 8'h11 |=> rsp_tail)
      else $error("bad rsp length");
   rsp_cause_a: assert property (m2h_valid && mp_reg == 6'h00 && m2h_data == 8'h11 |-> $past(h2m_last))
      else $error("rsp unasked");
   rsp_echo_a: assert property (m2h_valid && mp_reg == 6'h01 && mt_reg == 8'h11 |-> m2h_data == hch_reg)
      else $error("rsp chan differs");
   rsp_status_a: assert property (m2h_valid && mp_reg == 6'h02 && mt_reg == 8'h11 |-> m2h_data < 8'h02)
      else $error("bad rsp status");
   txn_fresh_a: assert property (m2h_valid && mp_reg == 6'h02 && mt_reg == 8'h12
      |-> {$past(m2h_data), m2h_data} != tx_reg) else $error("txn repeated");
   one_up_a: assert property (at_t && m2h_data == 8'h18 |-> !up_reg)
      else $error("two up flows");
   sf_given_a: assert property (m2h_valid && m2h_last && mt_reg == 8'h12 |-> sf_reg)
      else $error("no flow");
   digest_last_a: assert property (at_t && m2h_data == 8'h1C |-> key_reg ##1 dig_tail)
      else $error("digest not last");
endmodule : link_properties

/* tb_upstream_change_and_flow_add.sv */
// Testbench: both ends back to back
`timescale 1ns/1ps
module tb_upstream_change_and_flow_add;
   logic clk = 1'h0;
   logic resetn = 1'h0;
   logic sw_start, sw_rng_en, fa_start, fa_up, fa_dn, use_cls, hs, privacy_en, range_done;
   logic [7:0] sw_chan, sw_rng_val, fa_param, key_seq, digest, up_chan, rx_type, rx_b1, rx_b2;
   logic [1:0] cls, range_mode;
   logic [15:0] m_txn, h_txn;
   logic range_active, switch_done, fa_sent, rx_valid;
   int failures = 0;
   int checks_done = 0;
   int sd_cnt = 0;
   always #5 clk = ~clk;
   // Counted on the edge that ends the pulse, so reads never race it
   always @(posedge clk) if (switch_done === 1'h1) sd_cnt++;
   msg_link_if link ();
   subscriber_modem_end u_subscriber_modem_end (.clk, .resetn, .link, .chan_load(1'h0), .chan_load_val(8'h00),
      .up_chan, .range_active, .range_mode, .range_done, .switch_done, .fa_start, .fa_up, .fa_dn,
      .fa_use_class(use_cls), .fa_param, .fa_cls_count(cls), .fa_header_suppression(hs),
      .privacy_en, .key_seq, .digest, .fa_ready(), .fa_sent, .fa_txn(m_txn));
   headend_controller_end u_headend_controller_end (.clk, .resetn, .link, .sw_start, .sw_chan, .sw_rng_en,
      .sw_rng_val, .fa_start, .fa_dir_up(fa_up), .fa_sfid({fa_param, key_seq}),
      .fa_upstream_service_identifier({key_seq, fa_param}), .fa_qos(fa_param), .fa_cls_count(cls), .privacy_en,
      .key_seq, .digest, .cmd_ready(), .fa_txn(h_txn), .rx_valid, .rx_type, .rx_b1, .rx_b2);
   link_properties u_link_properties (.clk, .resetn, .h2m_valid(link.h2m_valid),
      .h2m_data(link.h2m_data), .h2m_last(link.h2m_last), .m2h_valid(link.m2h_valid), .m2h_data(link.m2h_data),
      .m2h_last(link.m2h_last));
   task automatic chk(input logic [23:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic test_done();
      $display("checks=%0d failures=%0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done
   task automatic wait_rx();
      int n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (rx_valid !== 1'h1 && n < 300);
      if (n >= 300) begin
         failures++;
         test_done();
      end
   endtask : wait_rx
   task automatic quiet();
      int seen = 0;
      repeat (20) begin
         @(negedge clk);
         if (rx_valid === 1'h1) seen++;
      end
      chk(24'(seen), 24'h000000);
   endtask : quiet
   task automatic send_sw(input logic [7:0] ch, input logic en, input logic [7:0] rv);
      @(posedge clk);
      sw_start <= 1'h1;
      sw_chan <= ch;
      sw_rng_en <= en;
      sw_rng_val <= rv;
      @(posedge clk);
      sw_start <= 1'h0;
   endtask : send_sw
   task automatic end_range();
      @(posedge clk);
      range_done <= 1'h1;
      @(posedge clk);
      range_done <= 1'h0;
      repeat (2) @(negedge clk);
   endtask : end_range
   task automatic t_switch();
      send_sw(8'h05, 1'h0, 8'h00);
      wait_rx();
      chk({rx_type, rx_b1, rx_b2}, 24'h110500);
      chk({13'h0000, range_active, range_mode, up_chan}, 24'h000405);
      send_sw(8'h09, 1'h0, 8'h00);
      quiet();
      end_range();
      chk({7'h00, range_active, 8'(sd_cnt), up_chan}, 24'h000105);
      $display("switch test done");
   endtask : t_switch
   task automatic t_modes();
      for (int v = 0; v < 4; v++) begin
         send_sw(8'h10 + 8'(v), 1'h1, 8'(v));
         wait_rx();
         chk({rx_type, rx_b1, rx_b2}, {16'h1110 + 16'(v), 8'h00});
         chk({15'h0000, range_active, up_chan}, {15'h0000, v < 3, 8'h10 + 8'(v)});
         if (v < 3) begin
            chk({22'h000000, range_mode}, 24'(v));
            end_range();
         end else begin
            quiet();
         end
         chk(24'(sd_cnt), 24'(v + 2));
      end
      $display("ranging test done");
   endtask : t_modes
   task automatic t_same();
      send_sw(8'h13, 1'h0, 8'h00);
      wait_rx();
      chk({rx_type, rx_b1, rx_b2}, 24'h111301);
      quiet();
      chk({7'h00, range_active, 8'(sd_cnt), up_chan}, 24'h000513);
      $display("same channel test done");
   endtask : t_same
   task automatic t_fadd();
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         fa_start <= 1'h1;
         fa_up <= i == 0;
         fa_dn <= i < 2;
         use_cls <= i == 1;
         hs <= i == 0;
         cls <= 2'(i + 2);
         privacy_en <= i == 0;
         @(posedge clk);
         fa_start <= 1'h0;
         if (i < 2) begin
            wait_rx();
            chk({rx_type, rx_b1, rx_b2}, {16'h1200, 8'(i + 1)});
            chk({23'h000000, fa_sent}, 24'h000001);
         end else begin
            quiet();
         end
         repeat (2) @(negedge clk);
         chk({h_txn[7:0], m_txn}, {8'(i + 2), 16'(i < 2 ? i + 2 : 3)});
      end
      $display("flow add test done");
   endtask : t_fadd
   initial begin
      {sw_start, sw_rng_en, fa_start, fa_up, fa_dn, use_cls, hs, privacy_en, range_done} = '0;
      {sw_chan, sw_rng_val, fa_param, key_seq, digest, cls} = {16'h0000, 24'h334455, 2'h0};
      repeat (6) @(posedge clk);
      resetn <= 1'h1;
      t_switch();
      t_modes();
      t_same();
      t_fadd();
      test_done();
   end
endmodule : tb_upstream_change_and_flow_add
